// ===== src/two_wire_port_consts.vh
// Constants for the two-wire master/slave serial port
// Overview of operation
// - Port works in two-wire mode only while port_enable, control bit 5, is set.
// - Low four control bits select 7-bit slave, 10-bit slave or master.
// - Master clock rate is oscillator over four times baud value plus one; the code gives oscillator over two times baud value plus one.
// - Start and stop flags clear on reset and while the port is disabled.
// - Bus may be claimed after a stop, or when idle with both flags clear.
// - In master mode hardware itself drives clock and data line timing.
// - Interrupt flag sets on start, stop, repeated start, byte done, ack done.
// - Master reception starts when receive_enable, control-two bit 3, is set.
// - Receive enable set while not idle is ignored.
// - Each baud rollover toggles the clock line; those that raise it also shift in a data bit.
// - After eighth falling clock: enter hold, load buffer, set flags, hold clock low.
// - Buffer-full sets when a byte enters the buffer, clears on buffer read.
// - Setting ack_sequence_enable, control-two bit 4, sends an acknowledge bit.
// - Overflow sets when eight bits arrive while buffer-full is still set.
// - Buffer write during a shift sets write collision and is discarded.
// - Both line inputs always pass a spike filter, whatever the mode.
// - Slave supports 7-bit, 10-bit addressing and general call; in 10-bit mode the code matches only the prefix byte.
`ifndef TWO_WIRE_PORT_CONSTS_VH
`define TWO_WIRE_PORT_CONSTS_VH
`define CTL_ENABLE_BIT     5
`define CTL_MODE_MSB       3
`define CTL2_RCV_BIT       3
`define CTL2_ACK_BIT       4
`define MODE_SLAVE7        4'h6
`define MODE_SLAVE10       4'h7
`define MODE_MASTER        4'h8
`define OSC_DIV            4
`define FILTER_LEN         3
`define GENERAL_CALL_ADDR  8'h00
`define TEN_BIT_PREFIX     5'h1E
`endif

// ===== src/two_wire_port_module.v
// Two-wire serial port: master receive, slave addressing, bus condition tracking
`timescale 1ns/1ps
`include "two_wire_port_consts.vh"
module two_wire_port_module (
  input  wire       clk_sys_i,
  input  wire       rst_i,
  input  wire       clk_en_i,
  input  wire [7:0] port_control_reg_i,
  input  wire [7:0] port_control_reg_two_i,
  input  wire [7:0] address_baud_reg_i,
  input  wire [7:0] slave_addr_low_i,
  input  wire       buf_wr_i,
  input  wire [7:0] buf_wdata_i,
  input  wire       buf_rd_i,
  input  wire       ack_value_i,
  input  wire       flag_clear_i,
  input  wire       ovf_clear_i,
  input  wire       write_collision_flag_clear_i,
  input  wire       scl_i,
  input  wire       sda_i,
  output wire       scl_o,
  output wire       scl_oe_o,
  output wire       sda_o,
  output wire       sda_oe_o,
  output wire [7:0] rx_tx_buffer_o,
  output wire       buffer_full_flag_o,
  output wire       receive_overflow_flag_o,
  output wire       write_collision_flag_o,
  output wire       serial_irq_flag_o,
  output wire       start_seen_o,
  output wire       stop_seen_o,
  output wire       bus_free_o,
  output wire       idle_o,
  output wire       slave_match_o,
  output wire       general_call_o,
  output wire       rx_valid_o,
  output wire [7:0] rx_data_o,
  input  wire       rx_ready_i
);
  localparam [3:0] ST_IDLE = 4'h1;
  localparam [3:0] ST_RECV = 4'h2;
  localparam [3:0] ST_ACK  = 4'h4;
  localparam [3:0] ST_HOLD = 4'h8;

  wire       enable_w = port_control_reg_i[`CTL_ENABLE_BIT];
  wire [3:0] mode_w   = port_control_reg_i[`CTL_MODE_MSB:0];
  wire       master_w = enable_w && (mode_w == `MODE_MASTER);
  wire       slave_w  = enable_w && (mode_w == `MODE_SLAVE7 || mode_w == `MODE_SLAVE10);

  // Spike filter: a line level is accepted only after it holds steady for the filter length
  reg [`FILTER_LEN-1:0] scl_sh_reg;
  reg [`FILTER_LEN-1:0] sda_sh_reg;
  reg                   scl_f_reg;
  reg                   sda_f_reg;
  reg                   scl_q_reg;
  reg                   sda_q_reg;
  always @(posedge clk_sys_i or posedge rst_i)
    if (rst_i)
    begin
      scl_sh_reg <= {`FILTER_LEN{1'b1}};
      sda_sh_reg <= {`FILTER_LEN{1'b1}};
      scl_f_reg  <= 1'b1;
      sda_f_reg  <= 1'b1;
      scl_q_reg  <= 1'b1;
      sda_q_reg  <= 1'b1;
    end
    else if (clk_en_i)
    begin
      scl_sh_reg <= {scl_sh_reg[`FILTER_LEN-2:0], scl_i};
      sda_sh_reg <= {sda_sh_reg[`FILTER_LEN-2:0], sda_i};
      if (&scl_sh_reg || ~|scl_sh_reg)
        scl_f_reg <= scl_sh_reg[0];
      if (&sda_sh_reg || ~|sda_sh_reg)
        sda_f_reg <= sda_sh_reg[0];
      scl_q_reg  <= scl_f_reg;
      sda_q_reg  <= sda_f_reg;
    end

  // Conditions are judged on filtered levels, so a spike cannot fake a start or stop
  wire start_ev_w = scl_f_reg && scl_q_reg && sda_q_reg && !sda_f_reg;
  wire stop_ev_w  = scl_f_reg && scl_q_reg && !sda_q_reg && sda_f_reg;
  wire scl_rise_w = scl_f_reg && !scl_q_reg;

  // Start and stop tracking
  reg start_reg;
  reg stop_reg;
  reg busy_reg;
  always @(posedge clk_sys_i or posedge rst_i)
    if (rst_i)
    begin
      start_reg <= 1'b0;
      stop_reg  <= 1'b0;
      busy_reg  <= 1'b0;
    end
    else if (clk_en_i)
    begin
      if (!enable_w)
      begin
        start_reg <= 1'b0;
        stop_reg  <= 1'b0;
        busy_reg  <= 1'b0;
      end
      else if (start_ev_w)
      begin
        start_reg <= 1'b1;
        stop_reg  <= 1'b0;
        busy_reg  <= 1'b1;
      end
      else if (stop_ev_w)
      begin
        start_reg <= 1'b0;
        stop_reg  <= 1'b1;
        busy_reg  <= 1'b0;
      end
    end
  assign bus_free_o = enable_w && (stop_reg || (!start_reg && !stop_reg));

  // Master receive engine
  reg [3:0] state_reg;
  reg [7:0] baud_cnt_reg;
  reg [3:0] edge_cnt_reg;
  reg       scl_drv_reg;
  reg       sda_drv_reg;
  reg [7:0] shift_reg;
  reg [7:0] buffer_reg;
  reg       bf_reg;
  reg       ovf_reg;
  reg       write_collision_flag_reg;
  reg       irq_reg;
  reg       byte_done_reg;
  reg       ack_done_reg;

  wire idle_w    = (state_reg == ST_IDLE) || (state_reg == ST_HOLD);
  wire rcv_req_w = port_control_reg_two_i[`CTL2_RCV_BIT];
  wire ack_req_w = port_control_reg_two_i[`CTL2_ACK_BIT];
  wire rollover_w = (baud_cnt_reg == 8'h00);
  reg  rcv_q_reg;
  reg  ack_q_reg;
  wire rcv_go_w = rcv_req_w && !rcv_q_reg && master_w && idle_w;
  wire ack_go_w = ack_req_w && !ack_q_reg && master_w && idle_w;

  // Slave address match; 10-bit mode checks the prefix byte of the high address bits
  reg [7:0] slv_shift_reg;
  reg [3:0] slv_cnt_reg;
  reg       slv_first_reg;
  reg       match_reg;
  reg       gcall_reg;
  wire      slv_byte_w = slave_w && scl_rise_w && (slv_cnt_reg == 4'h7) && slv_first_reg;
  wire [7:0] slv_byte_v = {slv_shift_reg[6:0], sda_f_reg};

  // Address byte that earns an interrupt: own address in the selected width, or general call
  wire addr7_hit_w  = (slv_byte_v[7:1] == slave_addr_low_i[7:1]);
  wire addr10_hit_w = (slv_byte_v[7:3] == `TEN_BIT_PREFIX) &&
                      (slv_byte_v[2:1] == slave_addr_low_i[2:1]);
  wire gcall_hit_w  = (slv_byte_v == `GENERAL_CALL_ADDR);
  wire own_hit_w    = (mode_w == `MODE_SLAVE10) ? addr10_hit_w : addr7_hit_w;

  // Byte is complete at the eighth falling clock; the line then stays low until the next command
  wire rx_load_w = (state_reg == ST_RECV) && rollover_w && scl_drv_reg &&
                   (edge_cnt_reg == 4'hF);

  // Two-entry buffer toward the data receiver
  reg [7:0] fifo_mem [0:1];
  reg       wr_ptr_reg;
  reg       rd_ptr_reg;
  reg [1:0] count_reg;
  // A full stream drops the new byte; the receiver must keep up or lose it
  wire fifo_push_w = rx_load_w && (count_reg != 2'h2);
  wire fifo_pop_w  = rx_ready_i && (count_reg != 2'h0);

  always @(posedge clk_sys_i or posedge rst_i)
    if (rst_i)
    begin
      state_reg     <= ST_IDLE;
      baud_cnt_reg  <= 8'h00;
      edge_cnt_reg  <= 4'h0;
      scl_drv_reg   <= 1'b1;
      sda_drv_reg   <= 1'b1;
      shift_reg     <= 8'h00;
      buffer_reg    <= 8'h00;
      bf_reg        <= 1'b0;
      ovf_reg       <= 1'b0;
      write_collision_flag_reg      <= 1'b0;
      irq_reg       <= 1'b0;
      rcv_q_reg     <= 1'b0;
      ack_q_reg     <= 1'b0;
      byte_done_reg <= 1'b0;
      ack_done_reg  <= 1'b0;
      slv_shift_reg <= 8'h00;
      slv_cnt_reg   <= 4'h0;
      slv_first_reg <= 1'b0;
      match_reg     <= 1'b0;
      gcall_reg     <= 1'b0;
      wr_ptr_reg    <= 1'b0;
      rd_ptr_reg    <= 1'b0;
      count_reg     <= 2'h0;
      fifo_mem[0]   <= 8'h00;
      fifo_mem[1]   <= 8'h00;
    end
    else if (clk_en_i)
    begin
      rcv_q_reg     <= rcv_req_w;
      ack_q_reg     <= ack_req_w;
      byte_done_reg <= 1'b0;
      ack_done_reg  <= 1'b0;
      if (!master_w)
      begin
        state_reg   <= ST_IDLE;
        scl_drv_reg <= 1'b1;
        sda_drv_reg <= 1'b1;
      end
      else
        case (state_reg)
          ST_IDLE, ST_HOLD:
          begin
            if (rcv_go_w)
            begin
              state_reg    <= ST_RECV;
              baud_cnt_reg <= address_baud_reg_i;
              edge_cnt_reg <= 4'h0;
              // Clock goes low first, so every byte starts in the same phase after idle or hold
              scl_drv_reg  <= 1'b0;
              sda_drv_reg  <= 1'b1;
            end
            else if (ack_go_w)
            begin
              state_reg    <= ST_ACK;
              baud_cnt_reg <= address_baud_reg_i;
              edge_cnt_reg <= 4'h0;
              sda_drv_reg  <= ack_value_i;
            end
          end
          ST_RECV:
          begin
            if (!rollover_w)
              baud_cnt_reg <= baud_cnt_reg - 8'h01;
            else
            begin
              baud_cnt_reg <= address_baud_reg_i;
              scl_drv_reg  <= ~scl_drv_reg;
              edge_cnt_reg <= edge_cnt_reg + 4'h1;
              if (!scl_drv_reg)
                shift_reg <= {shift_reg[6:0], sda_f_reg};
              if (rx_load_w)
              begin
                state_reg      <= ST_HOLD;
                byte_done_reg  <= 1'b1;
                if (bf_reg)
                  ovf_reg <= 1'b1;
                else
                  buffer_reg <= shift_reg;
                bf_reg <= 1'b1;
              end
            end
          end
          ST_ACK:
          begin
            if (!rollover_w)
              baud_cnt_reg <= baud_cnt_reg - 8'h01;
            else
            begin
              baud_cnt_reg <= address_baud_reg_i;
              scl_drv_reg  <= ~scl_drv_reg;
              edge_cnt_reg <= edge_cnt_reg + 4'h1;
              if (edge_cnt_reg == 4'h1)
              begin
                state_reg    <= ST_HOLD;
                ack_done_reg <= 1'b1;
                // Data line freed with the falling clock, so the slave may set its next bit
                sda_drv_reg  <= 1'b1;
              end
            end
          end
          default:
            state_reg <= ST_IDLE;
        endcase
      // Buffer read clears full; a new byte loading in the same cycle still wins
      if (buf_rd_i && !rx_load_w)
        bf_reg <= 1'b0;
      // A collision sets the flag even when its clear arrives in the same cycle
      if (buf_wr_i && (state_reg == ST_RECV))
        write_collision_flag_reg <= 1'b1;
      else if (write_collision_flag_clear_i)
        write_collision_flag_reg <= 1'b0;
      if (buf_wr_i && (state_reg != ST_RECV))
        buffer_reg <= buf_wdata_i;
      if (ovf_clear_i && !(rx_load_w && bf_reg))
        ovf_reg <= 1'b0;
      if (start_ev_w || stop_ev_w || byte_done_reg || ack_done_reg ||
          (slv_byte_w && (own_hit_w || gcall_hit_w)))
        irq_reg <= 1'b1;
      else if (flag_clear_i)
        irq_reg <= 1'b0;
      // Slave address capture
      if (!slave_w || start_ev_w)
      begin
        slv_cnt_reg   <= 4'h0;
        slv_first_reg <= start_ev_w;
        match_reg     <= 1'b0;
        gcall_reg     <= 1'b0;
      end
      else if (scl_rise_w && slv_first_reg)
      begin
        slv_shift_reg <= slv_byte_v;
        slv_cnt_reg   <= slv_cnt_reg + 4'h1;
        if (slv_byte_w)
        begin
          slv_first_reg <= 1'b0;
          gcall_reg     <= (slv_byte_v == `GENERAL_CALL_ADDR);
          if (mode_w == `MODE_SLAVE10)
            match_reg <= (slv_byte_v[7:3] == `TEN_BIT_PREFIX) &&
                         (slv_byte_v[2:1] == slave_addr_low_i[2:1]);
          else
            match_reg <= (slv_byte_v[7:1] == slave_addr_low_i[7:1]);
        end
      end
      if (fifo_push_w)
      begin
        fifo_mem[wr_ptr_reg] <= shift_reg;
        wr_ptr_reg <= ~wr_ptr_reg;
      end
      if (fifo_pop_w)
        rd_ptr_reg <= ~rd_ptr_reg;
      count_reg <= count_reg + {1'b0, fifo_push_w} - {1'b0, fifo_pop_w};
    end

  assign scl_o   = 1'b0;
  assign sda_o   = 1'b0;
  assign scl_oe_o = master_w && !scl_drv_reg;
  assign sda_oe_o = master_w && !sda_drv_reg;
  assign rx_tx_buffer_o          = buffer_reg;
  assign buffer_full_flag_o      = bf_reg;
  assign receive_overflow_flag_o = ovf_reg;
  assign write_collision_flag_o  = write_collision_flag_reg;
  assign serial_irq_flag_o       = irq_reg;
  assign start_seen_o            = start_reg;
  assign stop_seen_o             = stop_reg;
  assign idle_o                  = idle_w && !busy_reg;
  assign slave_match_o           = match_reg;
  assign general_call_o          = gcall_reg;
  assign rx_valid_o              = (count_reg != 2'h0);
  assign rx_data_o               = fifo_mem[rd_ptr_reg];
endmodule

// ===== dv/two_wire_port_checker.sv
// Concurrent checks on the two-wire port module ports
`timescale 1ns/1ps
`include "two_wire_port_consts.vh"
module two_wire_port_checker (
  input wire       clk_sys_i,
  input wire       rst_i,
  input wire       clk_en_i,
  input wire [7:0] port_control_reg_i,
  input wire [7:0] port_control_reg_two_i,
  input wire [7:0] address_baud_reg_i,
  input wire       buf_wr_i,
  input wire       buf_rd_i,
  input wire       flag_clear_i,
  input wire       scl_oe_o,
  input wire       sda_oe_o,
  input wire       buffer_full_flag_o,
  input wire       receive_overflow_flag_o,
  input wire       write_collision_flag_o,
  input wire       serial_irq_flag_o,
  input wire       start_seen_o,
  input wire       stop_seen_o,
  input wire       idle_o
);
  wire off = !port_control_reg_i[`CTL_ENABLE_BIT] && clk_en_i;
  wire on  = port_control_reg_i[`CTL_ENABLE_BIT] && clk_en_i;
  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (rst_i);
  sequence s_rcv_req;
    $rose(port_control_reg_two_i[`CTL2_RCV_BIT]) && on && idle_o &&
      port_control_reg_i[3:0] == `MODE_MASTER;
  endsequence
  sequence s_hold;
    $stable(scl_oe_o)[*7];
  endsequence
  property p_off_flags;
    off[*2] |-> !start_seen_o && !stop_seen_o;
  endproperty
  property p_off_lines;
    off[*3] |-> !scl_oe_o && !sda_oe_o;
  endproperty
  property p_rcv_start;
    s_rcv_req |-> ##[1:2] !idle_o;
  endproperty
  property p_bf_irq;
    $rose(buffer_full_flag_o) |=> serial_irq_flag_o;
  endproperty
  property p_bf_clear;
    buf_rd_i && idle_o && $past(idle_o) |=> !buffer_full_flag_o;
  endproperty
  property p_write_collision_flag;
    buf_wr_i && !idle_o |=> write_collision_flag_o;
  endproperty
  property p_ovf;
    $rose(receive_overflow_flag_o) |-> $past(buffer_full_flag_o);
  endproperty
  property p_irq_hold;
    serial_irq_flag_o && !flag_clear_i && on |=> serial_irq_flag_o;
  endproperty
  property p_scl_rate;
    $changed(scl_oe_o) && !idle_o && address_baud_reg_i == 8'h07 |=> s_hold;
  endproperty
  a_off_flags: assert property (p_off_flags) else $error("start/stop flag set while off");
  a_off_lines: assert property (p_off_lines) else $error("line driven while off");
  a_rcv_start: assert property (p_rcv_start) else $error("receive not started");
  a_bf_irq: assert property (p_bf_irq) else $error("no irq after byte load");
  a_bf_clear: assert property (p_bf_clear) else $error("buffer-full not cleared");
  a_write_collision_flag: assert property (p_write_collision_flag) else $error("write collision missed");
  a_ovf: assert property (p_ovf) else $error("overflow without buffer-full");
  a_irq_hold: assert property (p_irq_hold) else $error("irq flag dropped");
  a_scl_rate: assert property (p_scl_rate) else $error("clock half period wrong");
endmodule

// ===== dv/two_wire_slave_model.sv
// Far-side slave that serves bytes to master reads and makes bus conditions
`timescale 1ns/1ps
module two_wire_slave_model (
  input  wire scl_i,
  output reg  scl_pull_o,
  output reg  sda_pull_o
);
  reg [7:0] byte_reg;
  integer   bit_cnt;
  initial
  begin
    scl_pull_o = 1'b0;
    sda_pull_o = 1'b0;
    byte_reg   = 8'h00;
    bit_cnt    = 9;
  end
  // Bits change only while the clock is low, so the master samples a settled level
  always @(negedge scl_i)
  begin
    if (bit_cnt < 8)
    begin
      sda_pull_o <= !byte_reg[7 - bit_cnt];
      bit_cnt    <= bit_cnt + 1;
    end
    else if (bit_cnt == 8)
    begin
      sda_pull_o <= 1'b0;
      bit_cnt    <= 9;
    end
  end
  // Hold time is over after the last rising clock, so the pull-up takes the line back
  always @(posedge scl_i)
    if (bit_cnt == 8)
      sda_pull_o <= #40 1'b0;
  // With the clock already held low the first bit goes out at once, else on the next fall
  task arm(input [7:0] v);
    begin
      byte_reg = v;
      if (!scl_i)
      begin
        sda_pull_o = !v[7];
        bit_cnt    = 1;
      end
      else
        bit_cnt = 0;
    end
  endtask
  // Address byte from a far-side master: start, eight bits MSB first, a ninth clock, stop
  task addr(input [7:0] v);
    integer k;
    begin
      sda_pull_o = 1'b1;
      #40;
      for (k = 0; k < 8; k = k + 1)
      begin
        scl_pull_o = 1'b1;
        sda_pull_o = !v[7 - k];
        #40;
        scl_pull_o = 1'b0;
        #40;
      end
      scl_pull_o = 1'b1;
      sda_pull_o = 1'b1;
      #40;
      scl_pull_o = 1'b0;
      #40;
      sda_pull_o = 1'b0;
      #40;
    end
  endtask
  // Start then stop, only issued while the bus is idle
  task cond;
    sda_pull_o = 1'b1;
    #100;
    sda_pull_o = 1'b0;
    #100;
  endtask
endmodule

// ===== dv/i2c_master_slave_port_tb_top.sv
// Self-checking bench for the two-wire port module
`timescale 1ns/1ps
bind two_wire_port_module two_wire_port_checker u_chk (.*);
module i2c_master_slave_port_tb_top;
  reg        clk_sys_i = 1'b0;
  reg        rst_i = 1'b1;
  reg  [7:0] ctl = 8'h00, ctl2 = 8'h00, wdata = 8'h00, saddr = 8'h00;
  reg        wr = 1'b0, rd = 1'b0, fclr = 1'b0, rdy = 1'b0;
  wire       scl_oe, sda_oe, pscl, psda, bf, ovf, write_collision_flag, irq, sst, pst, bfree, idle, rxv;
  wire [7:0] buffer, rxd;
  wire       scl_out, sda_out, smatch, gcall;
  wire       scl_w = (scl_oe ? scl_out : 1'b1) && !pscl;
  wire       sda_w = (sda_oe ? sda_out : 1'b1) && !psda;
  integer    failures = 0, n_checks = 0, cyc = 0, i;
  reg  [7:0] exp_q[$];
  reg  [7:0] b[0:3];
  two_wire_port_module DUT (
    .clk_sys_i(clk_sys_i), .rst_i(rst_i), .clk_en_i(1'b1), .port_control_reg_i(ctl),
    .port_control_reg_two_i(ctl2), .address_baud_reg_i(8'h07), .slave_addr_low_i(saddr),
    .buf_wr_i(wr), .buf_wdata_i(wdata), .buf_rd_i(rd), .ack_value_i(1'b0),
    .flag_clear_i(fclr), .ovf_clear_i(1'b0), .write_collision_flag_clear_i(1'b0), .scl_i(scl_w),
    .sda_i(sda_w), .scl_o(scl_out), .scl_oe_o(scl_oe), .sda_o(sda_out), .sda_oe_o(sda_oe),
    .rx_tx_buffer_o(buffer), .buffer_full_flag_o(bf), .receive_overflow_flag_o(ovf),
    .write_collision_flag_o(write_collision_flag), .serial_irq_flag_o(irq), .start_seen_o(sst),
    .stop_seen_o(pst), .bus_free_o(bfree), .idle_o(idle), .slave_match_o(smatch),
    .general_call_o(gcall), .rx_valid_o(rxv), .rx_data_o(rxd), .rx_ready_i(rdy));
  two_wire_slave_model part (.scl_i(scl_w), .scl_pull_o(pscl), .sda_pull_o(psda));
  always #2 clk_sys_i = ~clk_sys_i;
  task chk(input [7:0] got, input [7:0] exp);
  begin
    n_checks = n_checks + 1;
    if (got !== exp)
    begin
      failures = failures + 1;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  end
  endtask
  task tick(input integer n);
    repeat (n) @(posedge clk_sys_i);
    #1;
  endtask
  task tally_and_finish;
    $display("checks %0d failures %0d", n_checks, failures);
    if (failures == 0 && n_checks > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  // One read, an ack with a receive request that must be ignored, then flag clear
  task recv(input [7:0] v, input mid);
    integer k;
    part.arm(v);
    ctl2 = 8'h00;
    tick(1);
    ctl2 = 8'h08;
    tick(40);
    wr = mid;
    wdata = ~v;
    tick(1);
    wr = 1'b0;
    for (k = 0; k < 400 && idle !== 1'b1; k = k + 1)
      tick(1);
    tick(2);
    chk({6'h00, bf, irq}, 8'h03);
    ctl2 = 8'h10;
    tick(3);
    chk({7'h00, idle}, 8'h00);
    ctl2 = 8'h18;
    for (k = 0; k < 400 && idle !== 1'b1; k = k + 1)
      tick(1);
    tick(40);
    chk({6'h00, idle, irq}, 8'h03);
    fclr = 1'b1;
    tick(1);
    fclr = 1'b0;
  endtask
  // Stream consumer: each accepted word is matched against the oldest note
  always @(posedge clk_sys_i)
    if (!rst_i && rxv === 1'b1 && rdy)
      chk(rxd, exp_q.size() ? exp_q.pop_front() : 8'hXX);
  always @(posedge clk_sys_i)
  begin
    cyc = cyc + 1;
    if (cyc == 20000)
    begin
      failures = failures + 1;
      tally_and_finish;
    end
  end
  initial
  begin
    i = $urandom(93);
    for (i = 0; i < 4; i = i + 1)
      b[i] = $urandom;
    tick(20);
    rst_i = 1'b0;
    tick(2);
    chk({bf, ovf, write_collision_flag, irq, sst, pst, scl_oe, sda_oe}, 8'h00);
    for (i = 6; i < 9; i = i + 1)
    begin
      ctl = {4'h2, i[3:0]};
      tick(4);
      part.cond();
      tick(8);
      chk({5'h00, pst, bfree, irq}, 8'h07);
      ctl = 8'h00;
      fclr = 1'b1;
      tick(3);
      fclr = 1'b0;
      chk({6'h00, sst, pst}, 8'h00);
    end
    saddr = b[0];
    ctl = 8'h26;
    tick(4);
    part.addr({b[0][7:1], 1'b1});
    chk({6'h00, smatch, gcall}, 8'h02);
    part.addr(8'h00);
    chk({6'h00, smatch, gcall}, {6'h00, (b[0][7:1] == 7'h00), 1'b1});
    ctl = 8'h27;
    tick(4);
    part.addr({5'h1E, b[0][2:1], 1'b0});
    chk({6'h00, smatch, gcall}, 8'h02);
    chk({7'h00, irq}, 8'h01);
    ctl = 8'h00;
    fclr = 1'b1;
    tick(3);
    fclr = 1'b0;
    ctl = 8'h28;
    tick(4);
    exp_q.push_back(b[0]);
    recv(b[0], 1'b0);
    chk(buffer, b[0]);
    exp_q.push_back(b[1]);
    recv(b[1], 1'b1);
    chk({5'h00, ovf, write_collision_flag, rxv}, 8'h07);
    chk(buffer, b[0]);
    recv(b[2], 1'b0);
    rd = 1'b1;
    tick(1);
    rd = 1'b0;
    tick(1);
    chk({7'h00, bf}, 8'h00);
    rdy = 1'b1;
    tick(4);
    exp_q.push_back(b[3]);
    recv(b[3], 1'b0);
    chk(buffer, b[3]);
    chk({6'h00, rxv, bf}, 8'h01);
    chk(exp_q.size(), 8'h00);
    tally_and_finish;
  end
endmodule
